//--- logic/hwd_watchdog.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - 14-bit watchdog counter is off after any reset until armed.
// - Writing 1E then E1 to the service register arms the watchdog.
// - When armed, the counter advances once per machine cycle while oscillator runs.
// - Software cannot disarm; only reset or overflow returns to disabled.
// - Each complete 1E, E1 pair clears the count while armed.
// - Base counter overflows at 3FFF and resets the whole device.
// - Overflow drives an active-low reset pin pulse of 96 peripheral clocks.
// - The count value is neither readable nor writable by software.
// - Service register is write-only; reads return no defined data.
// - A 7-bit prescaler precedes the base counter to extend time-out.
// - Select field bits 2..0 at A7 give 16384 times 2^S cycles.
// - Select field resets to zero; upper bits reserved, not to be set.
// - During power-down the count freezes and no servicing is needed.
// - After wake by held-low interrupt, counting waits until it goes high.
module hwd_watchdog
    import hwd_pkg::*;
(
    input  wire logic       ref_clk_i,     // Peripheral clock, one machine cycle
    input  wire logic       reset_i,       // Synchronous device reset
    input  wire logic [7:0] addr_i,        // Register address
    input  wire logic [7:0] wdata_i,       // Write data
    input  wire logic       wr_i,          // Write strobe
    input  wire logic       rd_i,          // Read strobe
    output logic      [7:0] rdata_o,       // Read data, cycle after strobe
    input  wire logic       power_down_i,  // Oscillator stopped
    input  wire logic       wake_int_n_i,  // Wake interrupt pin level
    output logic            dev_reset_o,   // Device reset request
    output logic            rst_pin_out_o, // Reset pin drive level
    output logic            rst_pin_oe_o,  // Reset pin drive enable
    output logic            armed_o        // Watchdog running
);

    // ****************************************
    // Declarations
    // ****************************************
    logic                  armed_q;
    logic                  armed_d;
    logic [HWD_SEL_W-1:0]  sel_q;
    logic [HWD_SEL_W-1:0]  sel_d;
    logic [HWD_PRE_W-1:0]  pre_q;
    logic [HWD_PRE_W-1:0]  pre_d;
    logic [HWD_BASE_W-1:0] base_q;
    logic [HWD_BASE_W-1:0] base_d;
    logic                  hold_q;
    logic                  hold_d;
    logic [6:0]            pulse_q;
    logic [6:0]            pulse_d;
    logic                  pin_oe_q;
    logic                  pin_oe_d;
    logic                  pin_out_q;
    logic [7:0]            rdata_q;
    logic [7:0]            rdata_d;
    logic                  svc_done;

    // ****************************************
    // Address decode
    // ****************************************
    wire hit_service = addr_i == HWD_ADDR_SERVICE;
    wire hit_timeout = addr_i == HWD_ADDR_TIMEOUT;
    wire wr_service  = wr_i && hit_service;
    wire wr_timeout  = wr_i && hit_timeout;
    wire rd_timeout  = rd_i && hit_timeout;

    // ****************************************
    // Key pair detector
    // ****************************************
    hwd_seq_detect u_seq (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .wr_i      (wr_service),
        .data_i    (wdata_i),
        .done_o    (svc_done)
    );

    // ****************************************
    // Counting conditions
    // ****************************************
    // Clock stopped in power-down; hold also covers the wake window
    wire run_ok   = !power_down_i && !hold_q;
    wire count_en = armed_q && run_ok;

    // Low S prescaler bits all ones gives one base step per 2^S cycles
    wire [HWD_PRE_W-1:0] pre_mask = ~(HWD_PRE_ONES << sel_q);
    wire                 tick     = (pre_q & pre_mask) == pre_mask;
    wire                 at_max   = base_q == HWD_BASE_MAX;

    // Servicing in the same cycle beats the overflow
    wire overflow = count_en && tick && at_max && !svc_done;

    // ****************************************
    // Power-down hold
    // ****************************************
    always_comb
    begin
        hold_d = hold_q;
        if (power_down_i)
        begin
            hold_d = 1'b1;
        end
        else if (wake_int_n_i)
        begin
            hold_d = 1'b0;
        end
    end

    // ****************************************
    // Arming
    // ****************************************
    always_comb
    begin
        armed_d = armed_q;
        if (svc_done)
        begin
            armed_d = 1'b1;
        end
        else if (overflow)
        begin
            armed_d = 1'b0;
        end
    end

    // ****************************************
    // Prescaler and base counter
    // ****************************************
    always_comb
    begin
        pre_d  = pre_q;
        base_d = base_q;
        if (svc_done)
        begin
            pre_d  = HWD_PRE_RESET;
            base_d = HWD_BASE_RESET;
        end
        else if (count_en)
        begin
            pre_d = pre_q + 7'h01;
            if (tick)
            begin
                base_d = base_q + 14'h0001;
            end
        end
    end

    // ****************************************
    // Time-out select
    // ****************************************
    always_comb
    begin
        sel_d = sel_q;
        if (wr_timeout)
        begin
            // Reserved upper bits are dropped
            sel_d = wdata_i[HWD_SEL_LSB +: HWD_SEL_W];
        end
    end

    // ****************************************
    // Reset pulse
    // ****************************************
    always_comb
    begin
        pulse_d  = pulse_q;
        pin_oe_d = pin_oe_q;
        if (overflow)
        begin
            pulse_d  = HWD_PULSE_CYCLES;
            pin_oe_d = 1'b1;
        end
        else if (pulse_q != HWD_PULSE_RESET)
        begin
            pulse_d  = pulse_q - 7'h01;
            pin_oe_d = pulse_q != 7'h01;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Count is never mapped; service reads give zero
    always_comb
    begin
        rdata_d = HWD_RDATA_RESET;
        if (rd_timeout)
        begin
            rdata_d[HWD_SEL_LSB +: HWD_SEL_W] = sel_q;
            rdata_d[HWD_ARMED_BIT]            = armed_q;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            armed_q <= 1'b0;
            sel_q   <= HWD_SEL_RESET;
            pre_q   <= HWD_PRE_RESET;
            base_q  <= HWD_BASE_RESET;
            hold_q  <= 1'b0;
        end
        else
        begin
            armed_q <= armed_d;
            sel_q   <= sel_d;
            pre_q   <= pre_d;
            base_q  <= base_d;
            hold_q  <= hold_d;
        end
    end

    // The pulse must outlive the device reset it causes
    // Running pulse tested first so an unknown power-up state still clears
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i && pin_oe_q)
        begin
            pulse_q  <= pulse_d;
            pin_oe_q <= pin_oe_d;
        end
        else if (reset_i)
        begin
            pulse_q  <= HWD_PULSE_RESET;
            pin_oe_q <= 1'b0;
        end
        else
        begin
            pulse_q  <= pulse_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            rdata_q   <= HWD_RDATA_RESET;
            pin_out_q <= 1'b0;
        end
        else
        begin
            rdata_q   <= rdata_d;
            pin_out_q <= 1'b0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_o       = rdata_q;
    assign armed_o       = armed_q;
    assign dev_reset_o   = pin_oe_q;
    assign rst_pin_oe_o  = pin_oe_q;
    assign rst_pin_out_o = pin_out_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [7:0] oe_len_q;

    always_ff @(posedge ref_clk_i)
    begin
        oe_len_q <= pin_oe_q ? oe_len_q + 8'h01 : 8'h00;
    end

    sequence s_wrap;
        count_en && tick && at_max && !svc_done;
    endsequence

    sequence s_pulse_start;
        pin_oe_q && !armed_q;
    endsequence

    disarmed_reset_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> !armed_q && base_q == HWD_BASE_RESET)
        else $error("Watchdog not idle after reset");

    arm_on_pair_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        svc_done |=> armed_q)
        else $error("Key pair did not arm");

    count_step_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        count_en && !svc_done && !overflow
        |=> pre_q == $past(pre_q) + 7'h01)
        else $error("Prescaler did not advance");

    no_disarm_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        armed_q && !overflow |=> armed_q)
        else $error("Watchdog disarmed without reset");

    service_clear_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        svc_done |=> base_q == HWD_BASE_RESET && pre_q == HWD_PRE_RESET)
        else $error("Service did not clear the count");

    wrap_pulse_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        s_wrap |=> s_pulse_start ##1 dev_reset_o)
        else $error("Overflow gave no device reset");

    pulse_len_a: assert property (
        @(posedge ref_clk_i)
        $past(pin_oe_q) && !pin_oe_q |-> oe_len_q == 8'(HWD_PULSE_PERIODS))
        else $error("Reset pin pulse length wrong");

    service_read_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        rd_i && !hit_timeout |=> rdata_o == HWD_RDATA_RESET)
        else $error("Unmapped or service read not zero");

    base_tick_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        !svc_done && !(count_en && tick) |=> $stable(base_q))
        else $error("Base moved without a tick");

    sel_reset_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> sel_q == HWD_SEL_RESET)
        else $error("Select field not zero after reset");

    pd_freeze_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        power_down_i && !svc_done |=> $stable(pre_q) && $stable(base_q))
        else $error("Count moved in power-down");

    wake_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(power_down_i) && !wake_int_n_i |-> hold_q && !count_en)
        else $error("Counting resumed while wake pin low");

endmodule

`default_nettype wire

//--- include/hwd_pkg.sv
package hwd_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] HWD_ADDR_SERVICE = 8'hA6;
    localparam logic [7:0] HWD_ADDR_TIMEOUT = 8'hA7;
    localparam int         HWD_SEL_LSB      = 0;
    localparam int         HWD_ARMED_BIT    = 7;
    localparam logic [2:0] HWD_SEL_RESET    = 3'h0;
    localparam logic [7:0] HWD_RDATA_RESET  = 8'h00;

    // ****************************************
    // Service keys
    // ****************************************
    localparam logic [7:0] HWD_KEY_FIRST  = 8'h1E;
    localparam logic [7:0] HWD_KEY_SECOND = 8'hE1;

    // ****************************************
    // Counter shapes and timing
    // ****************************************
    localparam int          HWD_BASE_W        = 14;
    localparam int          HWD_PRE_W         = 7;
    localparam int          HWD_SEL_W         = 3;
    localparam logic [13:0] HWD_BASE_MAX      = 14'h3FFF;
    localparam logic [13:0] HWD_BASE_RESET    = 14'h0000;
    localparam logic [6:0]  HWD_PRE_RESET     = 7'h00;
    localparam logic [6:0]  HWD_PRE_ONES      = 7'h7F;
    localparam int          HWD_PULSE_PERIODS = 96;
    localparam logic [6:0]  HWD_PULSE_CYCLES  = 7'(HWD_PULSE_PERIODS);
    localparam logic [6:0]  HWD_PULSE_RESET   = 7'h00;

    // ****************************************
    // Sequence detector states
    // ****************************************
    typedef enum logic {
        HWD_SEQ_IDLE  = 1'b0,
        HWD_SEQ_FIRST = 1'b1
    } hwd_seq_t;

endpackage

//--- logic/hwd_seq_detect.sv
`timescale 1ns/100ps
`default_nettype none

module hwd_seq_detect
    import hwd_pkg::*;
(
    input  wire logic       ref_clk_i, // Peripheral clock
    input  wire logic       reset_i,   // Synchronous reset
    input  wire logic       wr_i,      // Write to service register
    input  wire logic [7:0] data_i,    // Written byte
    output logic            done_o     // Complete key pair seen
);

    hwd_seq_t state_q;
    hwd_seq_t state_d;
    logic     done_q;
    logic     done_d;

    wire is_first  = wr_i && (data_i == HWD_KEY_FIRST);
    wire is_second = wr_i && (data_i == HWD_KEY_SECOND);

    // ****************************************
    // Key pair tracking
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        done_d  = 1'b0;
        case (state_q)
            HWD_SEQ_IDLE:
            begin
                if (is_first)
                begin
                    state_d = HWD_SEQ_FIRST;
                end
            end
            HWD_SEQ_FIRST:
            begin
                if (wr_i)
                begin
                    // Any other byte drops the pair
                    state_d = HWD_SEQ_IDLE;
                    done_d  = is_second;
                end
            end
            default:
            begin
                state_d = HWD_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_q <= HWD_SEQ_IDLE;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_q  <= done_d;
        end
    end

    assign done_o = done_q;

    // ****************************************
    // Checks
    // ****************************************
    bad_second_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        state_q == HWD_SEQ_FIRST && wr_i && data_i != HWD_KEY_SECOND
        |=> state_q == HWD_SEQ_IDLE && !done_q)
        else $error("Wrong second byte was not dropped");

    lone_second_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        state_q == HWD_SEQ_IDLE |=> !done_q)
        else $error("Second key alone completed the pair");

    key_pair_a: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        state_q == HWD_SEQ_FIRST && is_second |=> done_q ##1 !done_q)
        else $error("Key pair did not give one pulse");

endmodule

`default_nettype wire

//--- sim/hwd_watchdog_bench.sv
`timescale 1ns/100ps
`default_nettype none

module hwd_watchdog_bench
    import hwd_pkg::*;
;
    typedef struct packed {
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } hwd_row_t;

    logic       ref_clk_i;
    logic       reset_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       power_down_i;
    logic       wake_int_n_i;
    logic       dev_reset_o;
    logic       rst_pin_out_o;
    logic       rst_pin_oe_o;
    logic       armed_o;
    int         n_fail;
    int         checks_done;
    int         n;
    logic [7:0] rd_v;
    hwd_row_t   rows [5];

    hwd_watchdog u_hwd_watchdog (
        .ref_clk_i     (ref_clk_i),
        .reset_i       (reset_i),
        .addr_i        (addr_i),
        .wdata_i       (wdata_i),
        .wr_i          (wr_i),
        .rd_i          (rd_i),
        .rdata_o       (rdata_o),
        .power_down_i  (power_down_i),
        .wake_int_n_i  (wake_int_n_i),
        .dev_reset_o   (dev_reset_o),
        .rst_pin_out_o (rst_pin_out_o),
        .rst_pin_oe_o  (rst_pin_oe_o),
        .armed_o       (armed_o)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // ****************************************
    // Bus and check helpers
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        rd_v = rdata_o;
    endtask

    task automatic service;
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_FIRST);
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_SECOND);
    endtask

    task automatic do_reset;
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // Edges from now to the pulse may shift by a cycle or two of pipeline
    task automatic wait_ovf(input int exp, input int tol);
        n = 0;
        #1;
        while (rst_pin_oe_o !== 1'b1 && n < exp + 10)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        checks_done++;
        if (n < exp - tol || n > exp + tol)
        begin
            n_fail++;
            $display("[FAIL] time to pulse expected %0d seen %0d", exp, n);
            close_out();
        end
        chk("armed after overflow", 8'h00, {7'h00, armed_o});
        chk("pin level", 8'h00, {7'h00, rst_pin_out_o});
        n = 0;
        while (rst_pin_oe_o === 1'b1 && dev_reset_o === 1'b1 && n < 200)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        chk("pulse width", 8'(HWD_PULSE_PERIODS), 8'(n));
        chk("pulse ends", 8'h00, {6'h00, rst_pin_oe_o, dev_reset_o});
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        n_fail       = 0;
        checks_done  = 0;
        reset_i      = 1'b1;
        addr_i       = 8'h00;
        wdata_i      = 8'h00;
        wr_i         = 1'b0;
        rd_i         = 1'b0;
        power_down_i = 1'b0;
        wake_int_n_i = 1'b1;
        rows[0] = '{HWD_ADDR_TIMEOUT, 8'hFF, 8'h07};
        rows[1] = '{HWD_ADDR_TIMEOUT, 8'h02, 8'h02};
        rows[2] = '{8'hA8, 8'h05, 8'h02};
        rows[3] = '{HWD_ADDR_SERVICE, 8'h55, 8'h02};
        rows[4] = '{HWD_ADDR_TIMEOUT, 8'h00, 8'h00};
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk("armed after reset", 8'h00, {7'h00, armed_o});
        rd_reg(HWD_ADDR_TIMEOUT);
        chk("select after reset", 8'h00, rd_v);
        rd_reg(HWD_ADDR_SERVICE);
        chk("service read", 8'h00, rd_v);
        rd_reg(8'h55);
        chk("unmapped read", 8'h00, rd_v);
        $display("Reset test done");

        foreach (rows[i])
        begin
            wr_reg(rows[i].waddr, rows[i].wdata);
            rd_reg(HWD_ADDR_TIMEOUT);
            chk("select readback", rows[i].exp, rd_v);
        end
        $display("Register table test done");

        // Broken pairs must leave the detector waiting for a fresh first key
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_SECOND);
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_FIRST);
        wr_reg(HWD_ADDR_SERVICE, 8'h55);
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_SECOND);
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk("armed after bad pairs", 8'h00, {7'h00, armed_o});
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_FIRST);
        wr_reg(HWD_ADDR_TIMEOUT, 8'h01);
        wr_reg(HWD_ADDR_SERVICE, HWD_KEY_SECOND);
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk("armed after pair", 8'h01, {7'h00, armed_o});
        rd_reg(HWD_ADDR_TIMEOUT);
        chk("armed in select read", 8'h81, rd_v);
        wr_reg(HWD_ADDR_TIMEOUT, 8'h00);
        wr_reg(HWD_ADDR_SERVICE, 8'h00);
        rd_reg(HWD_ADDR_SERVICE);
        chk("service read armed", 8'h00, rd_v);
        chk("no software disarm", 8'h01, {7'h00, armed_o});
        $display("Arming test done");

        repeat (15000) @(posedge ref_clk_i);
        service();
        wait_ovf(16386, 3);
        do_reset();
        rd_reg(HWD_ADDR_TIMEOUT);
        chk("select after device reset", 8'h00, rd_v);
        $display("Overflow test done");

        wr_reg(HWD_ADDR_TIMEOUT, 8'h01);
        service();
        wait_ovf(32770, 3);
        do_reset();
        $display("Extended time-out test done");

        service();
        repeat (8000) @(posedge ref_clk_i);
        power_down_i <= 1'b1;
        repeat (5000) @(posedge ref_clk_i);
        wake_int_n_i <= 1'b0;
        @(posedge ref_clk_i);
        power_down_i <= 1'b0;
        repeat (5000) @(posedge ref_clk_i);
        #1;
        chk("no pulse while frozen", 8'h01, {6'h00, rst_pin_oe_o, armed_o});
        @(posedge ref_clk_i);
        wake_int_n_i <= 1'b1;
        wait_ovf(8385, 4);
        $display("Power-down test done");
        close_out();
    end
endmodule

`default_nettype wire
